/* hdl/ccd_divider.sv */
// iterative restoring divider, one quotient bit per cycle
`timescale 1ns/1ns
`include "ccd_map.svh"
module ccd_divider
	import ccd_pkg::*;
#(
	parameter int WIDTH = `CCD_DIV_STEPS
)(
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             clkEn,
	input  wire logic             start,
	input  wire logic             signedOp,
	input  wire logic [WIDTH-1:0] dividend,
	input  wire logic [WIDTH-1:0] divisor,
	output logic                  finish,
	output logic      [WIDTH-1:0] quotient
);
	localparam int CW = $clog2(WIDTH + 1);

	logic [WIDTH:0]   rem_reg;
	logic [WIDTH-1:0] quo_reg;
	logic [WIDTH-1:0] den_reg;
	logic [CW-1:0]    cnt_reg;
	logic             run_reg;
	logic             zeroPend_reg;
	logic             neg_reg;
	logic [WIDTH:0]   trial;
	logic [WIDTH-1:0] absNum;
	logic [WIDTH-1:0] absDen;
	logic             stepping;

	assign absNum = (signedOp && dividend[WIDTH-1]) ? -dividend : dividend;
	assign absDen = (signedOp && divisor[WIDTH-1]) ? -divisor : divisor;
	assign trial = {rem_reg[WIDTH-1:0], quo_reg[WIDTH-1]} - {1'b0, den_reg};
	assign stepping = run_reg && (cnt_reg != '0);
	// a zero divisor skips the iteration, hence the short latency
	assign finish = zeroPend_reg || (run_reg && (cnt_reg == '0));
	assign quotient = zeroPend_reg ? '0 : (neg_reg ? -quo_reg : quo_reg);

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rem_reg      <= '0;
			quo_reg      <= '0;
			den_reg      <= '0;
			cnt_reg      <= '0;
			run_reg      <= 1'b0;
			zeroPend_reg <= 1'b0;
			neg_reg      <= 1'b0;
		end
		else if (clkEn)
		begin
			if (start)
			begin
				zeroPend_reg <= (divisor == '0);
				run_reg      <= (divisor != '0);
				cnt_reg      <= CW'(WIDTH);
				rem_reg      <= '0;
				quo_reg      <= absNum;
				den_reg      <= absDen;
				neg_reg      <= signedOp &&
					(dividend[WIDTH-1] ^ divisor[WIDTH-1]);
			end
			else if (stepping)
			begin
				cnt_reg <= cnt_reg - 1'b1;
				if (!trial[WIDTH])
				begin
					rem_reg <= trial;
					quo_reg <= {quo_reg[WIDTH-2:0], 1'b1};
				end
				else
				begin
					rem_reg <= {rem_reg[WIDTH-1:0], quo_reg[WIDTH-1]};
					quo_reg <= {quo_reg[WIDTH-2:0], 1'b0};
				end
			end
			else if (finish)
			begin
				run_reg      <= 1'b0;
				zeroPend_reg <= 1'b0;
			end
		end
	end

	generate
		if (WIDTH < 2)
		begin : g_badWidth
			$error("divider width must be at least 2");
		end
	endgenerate
endmodule // ccd_divider

/* hdl/ccd_exec.sv */
// execution unit: compare, divide, immediate prefix, loads, stream reads
//
// How it works
// - compare writes src_b minus src_a; equal sources give zero
// - result msb is replaced by "src_a greater than src_b"
// - unsigned_sel bit one compares unsigned, zero compares signed
// - blocking stream read stalls until the selected link holds a word
// - non-blocking read never stalls; carry 0 if word valid, 1 if not
// - data reads flag stream_error when the control bit is 1
// - control reads flag stream_error when the control bit is 0
// - stream read takes 2 cycles if non-blocking or data is ready
// - divide writes src_b over src_a, signedness from unsigned_sel
// - zero divisor sets div_zero_flag and writes zero
// - divide takes 2 cycles on zero divisor, otherwise 34
// - unprefixed immediate is the 16-bit field sign-extended
// - prefix latches upper half; next immediate instruction joins it
// - a non-immediate instruction after the prefix drops the latch
// - no interrupt between prefix and its partner; prefix takes 1 cycle
// - byte load puts 8 bits in the low byte, upper bytes cleared
// - load address is src_a plus src_b, or src_a plus immediate
// - halfword load clears address lsb, upper halfword cleared
`timescale 1ns/1ns
`include "ccd_map.svh"
module ccd_exec
	import ccd_pkg::*;
#(
	parameter int NUM_LINKS = 8
)(
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        clkEn,
	input  wire logic        issueValid,
	input  wire ccd_issue_s  issue,
	output logic             issueReady,
	output logic             done,
	output logic             destWe,
	output logic [31:0]      destValue,
	output logic             memReq,
	output logic [31:0]      memAddr,
	output logic             memHalf,
	input  wire logic        memAck,
	input  wire logic [15:0] memRdata,
	input  wire ccd_strm_s   strmIn [NUM_LINKS],
	output logic [NUM_LINKS-1:0] strmRead,
	input  wire logic        errClear,
	output ccd_status_s      status,
	output logic             immPending
);
	// msb-first field extraction
	function automatic logic [31:0] fld(input logic [31:0] w,
		input int pos, input int len);
		return (w >> (31 - pos - len + 1)) & ((32'h1 << len) - 32'h1);
	endfunction

	function automatic logic [31:0] sext16(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction

	ccd_state_e            state_reg;
	ccd_state_e            stateNext;
	logic                  issueReady_reg;
	logic                  done_reg;
	logic                  destWe_reg;
	logic [31:0]           destValue_reg;
	logic                  memReq_reg;
	logic [31:0]           memAddr_reg;
	logic                  memHalf_reg;
	logic [NUM_LINKS-1:0]  strmRead_reg;
	ccd_status_s           status_reg;
	logic                  immValid_reg;
	logic [15:0]           immLatch_reg;
	logic [2:0]            link_reg;
	logic                  nb_reg;
	logic                  ctl_reg;

	logic                  fire;
	logic [5:0]            opc;
	logic                  isTypeB;
	logic                  uns;
	logic                  isCmp;
	logic                  isDiv;
	logic                  isGet;
	logic                  isImm;
	logic                  isLoad;
	logic                  isHalf;
	logic [15:0]           ownImm;
	logic [31:0]           immOperand;
	logic [31:0]           loadAddr;
	logic [31:0]           diff;
	logic                  aGtB;
	logic [31:0]           cmpValue;
	logic                  linkOk;
	logic                  selValid;
	logic                  selCtl;
	logic [31:0]           selData;
	logic                  strmGo;
	logic                  divFinish;
	logic [31:0]           divQuot;
	logic                  inIdle;
	logic                  inStrm;
	logic                  inMem;
	logic                  inDiv;
	logic                  destWeNext;
	logic                  doneNext;
	logic [31:0]           destValueNext;
	logic                  memReqNext;
	logic                  carryNext;
	logic                  serrSet;
	logic                  dzSet;
	logic                  immValidNext;

	assign inIdle = (state_reg == CCD_IDLE);
	assign inStrm = (state_reg == CCD_STRM);
	assign inMem  = (state_reg == CCD_MEM);
	assign inDiv  = (state_reg == CCD_DIV);
	assign fire   = inIdle && issueValid && issueReady_reg;

	// decode
	assign opc     = 6'(fld(issue.instr, `CCD_OPC_POS, `CCD_OPC_LEN));
	assign isTypeB = 1'(fld(issue.instr, `CCD_TYPEB_POS, 1));
	assign uns     = 1'(fld(issue.instr, `CCD_UNS_POS, 1));
	assign ownImm  = 16'(fld(issue.instr, `CCD_IMM_POS, `CCD_IMM_LEN));
	assign isCmp   = (opc == `CCD_OPC_CMP);
	assign isDiv   = (opc == `CCD_OPC_DIV);
	assign isGet   = (opc == `CCD_OPC_GET);
	assign isImm   = (opc == `CCD_OPC_IMM);
	assign isHalf  = (opc == `CCD_OPC_LHU) || (opc == `CCD_OPC_LOAD_HALF_U_IMM);
	assign isLoad  = isHalf || (opc == `CCD_OPC_LBU) ||
		(opc == `CCD_OPC_LOAD_BYTE_U_IMM);

	// immediate operand, joined with a pending prefix
	assign immOperand = immValid_reg ? {immLatch_reg, ownImm}
		: sext16(ownImm);

	// address of a load
	assign loadAddr = (issue.srcA + (isTypeB ? immOperand : issue.srcB))
		& {31'h7fffffff, !isHalf};

	// compare
	assign diff = issue.srcB - issue.srcA;
	assign aGtB = uns ? (issue.srcA > issue.srcB)
		: ($signed(issue.srcA) > $signed(issue.srcB));
	assign cmpValue = (issue.srcA == issue.srcB) ? 32'h0
		: {aGtB, diff[30:0]};

	// selected stream link; an absent link looks permanently empty
	assign linkOk   = (32'(link_reg) < NUM_LINKS);
	assign selValid = linkOk && strmIn[link_reg].valid;
	assign selCtl   = linkOk && strmIn[link_reg].ctl;
	assign selData  = linkOk ? strmIn[link_reg].data : 32'h0;
	assign strmGo   = nb_reg || selValid;

	ccd_divider #(
		.WIDTH    (`CCD_DIV_STEPS)
	) u_div (
		.clk      (mclk),
		.srst     (srst),
		.clkEn    (clkEn),
		.start    (fire && isDiv),
		.signedOp (!uns),
		.dividend (issue.srcB),
		.divisor  (issue.srcA),
		.finish   (divFinish),
		.quotient (divQuot)
	);

	// sequencing
	always_comb
	begin
		stateNext = state_reg;
		case (state_reg)
			CCD_IDLE:
			begin
				if (fire && isGet)
					stateNext = CCD_STRM;
				else if (fire && isLoad)
					stateNext = CCD_MEM;
				else if (fire && isDiv)
					stateNext = CCD_DIV;
			end
			CCD_STRM:
			begin
				if (strmGo)
					stateNext = CCD_IDLE;
			end
			CCD_MEM:
			begin
				if (memAck)
					stateNext = CCD_IDLE;
			end
			CCD_DIV:
			begin
				if (divFinish)
					stateNext = CCD_IDLE;
			end
			default:
				stateNext = CCD_IDLE;
		endcase
	end

	// completion and result
	assign destWeNext = (fire && isCmp) || (inStrm && strmGo) ||
		(inMem && memAck) || (inDiv && divFinish);
	assign doneNext = destWeNext ||
		(fire && !isCmp && !isDiv && !isGet && !isLoad);
	// result only moves when it is written, so it holds through a stall
	assign destValueNext =
		(fire && isCmp) ? cmpValue :
		(inStrm && strmGo) ? selData :
		(inMem && memAck && memHalf_reg) ? {16'h0, memRdata} :
		(inMem && memAck) ? {24'h0, memRdata[7:0]} :
		(inDiv && divFinish) ? divQuot :
		destValue_reg;

	assign memReqNext = (fire && isLoad) || (inMem && !memAck);

	// status flags; a set in the clearing cycle wins
	assign carryNext = (inStrm && strmGo && nb_reg) ? !selValid
		: status_reg.carry;
	assign serrSet = inStrm && selValid && (selCtl != ctl_reg);
	assign dzSet   = fire && isDiv && (issue.srcA == 32'h0);

	// any instruction after the prefix consumes or drops it
	assign immValidNext = fire ? isImm : immValid_reg;

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			state_reg      <= CCD_IDLE;
			issueReady_reg <= 1'b1;
			done_reg       <= 1'b0;
			destWe_reg     <= 1'b0;
			destValue_reg  <= 32'h0;
			memReq_reg     <= 1'b0;
			memAddr_reg    <= 32'h0;
			memHalf_reg    <= 1'b0;
			status_reg     <= '{`CCD_RST_CARRY, `CCD_RST_SERR,
				`CCD_RST_DZERO};
			immValid_reg   <= 1'b0;
			immLatch_reg   <= 16'h0;
			link_reg       <= 3'h0;
			nb_reg         <= 1'b0;
			ctl_reg        <= 1'b0;
		end
		else if (clkEn)
		begin
			state_reg      <= stateNext;
			issueReady_reg <= (stateNext == CCD_IDLE);
			done_reg       <= doneNext;
			destWe_reg     <= destWeNext;
			destValue_reg  <= destValueNext;
			memReq_reg     <= memReqNext;
			status_reg.carry     <= carryNext;
			status_reg.streamErr <= serrSet ||
				(status_reg.streamErr && !errClear);
			status_reg.divZero   <= dzSet ||
				(status_reg.divZero && !errClear);
			immValid_reg   <= immValidNext;
			if (fire && isLoad)
			begin
				memAddr_reg <= loadAddr;
				memHalf_reg <= isHalf;
			end
			if (fire && isImm)
				immLatch_reg <= ownImm;
			if (fire && isGet)
			begin
				link_reg <= 3'(fld(issue.instr, `CCD_LINK_POS,
					`CCD_LINK_LEN));
				nb_reg   <= 1'(fld(issue.instr, `CCD_NB_POS, 1));
				ctl_reg  <= 1'(fld(issue.instr, `CCD_CTL_POS, 1));
			end
		end
	end

	// one pop strobe per link, raised only when a valid word was taken
	genvar gi;
	generate
		for (gi = 0; gi < NUM_LINKS; gi++)
		begin : g_pop
			always_ff @(posedge mclk)
			begin
				if (srst)
					strmRead_reg[gi] <= 1'b0;
				else if (clkEn)
					strmRead_reg[gi] <= inStrm && selValid &&
						(32'(link_reg) == gi);
			end
		end
		if (NUM_LINKS < 1 || NUM_LINKS > 8)
		begin : g_badLinks
			$error("link count must be 1 to 8");
		end
	endgenerate

	assign issueReady = issueReady_reg;
	assign done       = done_reg;
	assign destWe     = destWe_reg;
	assign destValue  = destValue_reg;
	assign memReq     = memReq_reg;
	assign memAddr    = memAddr_reg;
	assign memHalf    = memHalf_reg;
	assign strmRead   = strmRead_reg;
	assign status     = status_reg;
	// prefix pairs stay atomic: interrupts held off while pending
	assign immPending = immValid_reg;
endmodule // ccd_exec

/* include/ccd_map.svh */
// opcodes, field positions and cycle counts of the compare/divide/stream unit
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH

// field positions count bit 0 as the msb of the word
`define CCD_WORD_W      32
`define CCD_OPC_POS     0
`define CCD_OPC_LEN     6
`define CCD_TYPEB_POS   2
`define CCD_UNS_POS     30
`define CCD_NB_POS      17
`define CCD_CTL_POS     18
`define CCD_LINK_POS    29
`define CCD_LINK_LEN    3
`define CCD_IMM_POS     16
`define CCD_IMM_LEN     16

`define CCD_OPC_CMP     6'h05
`define CCD_OPC_DIV     6'h12
`define CCD_OPC_GET     6'h1b
`define CCD_OPC_IMM     6'h2c
`define CCD_OPC_LBU     6'h30
`define CCD_OPC_LHU     6'h31
`define CCD_OPC_LOAD_BYTE_U_IMM    6'h38
`define CCD_OPC_LOAD_HALF_U_IMM    6'h39

`define CCD_LAT_CMP     1
`define CCD_LAT_IMM     1
`define CCD_LAT_GET     2
`define CCD_LAT_LOAD    2
`define CCD_LAT_DIVZ    2
`define CCD_LAT_DIV     34
`define CCD_DIV_STEPS   32

`define CCD_RST_CARRY   1'b0
`define CCD_RST_SERR    1'b0
`define CCD_RST_DZERO   1'b0

`endif

/* include/ccd_pkg.sv */
// types shared by the compare/divide/stream unit
package ccd_pkg;

	typedef enum logic [1:0] {
		CCD_IDLE = 2'h0,
		CCD_STRM = 2'h1,
		CCD_MEM  = 2'h3,
		CCD_DIV  = 2'h2
	} ccd_state_e;

	typedef struct packed {
		logic [31:0] instr;
		logic [31:0] srcA;
		logic [31:0] srcB;
	} ccd_issue_s;

	typedef struct packed {
		logic [31:0] data;
		logic        ctl;
		logic        valid;
	} ccd_strm_s;

	typedef struct packed {
		logic carry;
		logic streamErr;
		logic divZero;
	} ccd_status_s;

endpackage

/* test/ccd_exec_sva.sv */
// concurrent checks on the execution unit ports
`timescale 1ns/1ns
`include "ccd_map.svh"
module ccd_exec_sva
	import ccd_pkg::*;
#(
	parameter int NUM_LINKS = 8
)(
	input wire logic                 mclk,
	input wire logic                 srst,
	input wire logic                 issueValid,
	input wire ccd_issue_s           issue,
	input wire logic                 issueReady,
	input wire logic                 done,
	input wire logic                 destWe,
	input wire logic [31:0]          destValue,
	input wire logic                 memReq,
	input wire logic [31:0]          memAddr,
	input wire logic                 memHalf,
	input wire logic                 memAck,
	input wire logic [NUM_LINKS-1:0] strmRead,
	input wire ccd_status_s          status,
	input wire logic                 immPending
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	logic        take;
	logic [5:0]  opc;
	logic        gt;
	logic [31:0] diff;
	logic [31:0] cmpExp;
	assign take = issueValid && issueReady;
	assign opc = issue.instr[31:26];
	assign gt = issue.instr[1] ? issue.srcA > issue.srcB
		: $signed(issue.srcA) > $signed(issue.srcB);
	assign diff = issue.srcB - issue.srcA;
	assign cmpExp = (diff == 32'h0) ? 32'h0 : {gt, diff[30:0]};
	sequence divRun;
		(!done)[*8] ##26 done;
	endsequence
	sequence zeroRun;
		status.divZero ##1 (done && destValue == 32'h0);
	endsequence
	cmp_value_a: assert property (take && opc == `CCD_OPC_CMP |=>
		done && destWe && destValue == $past(cmpExp)) else $error("cmp result");
	div_zero_a: assert property (take && opc == `CCD_OPC_DIV &&
		issue.srcA == 32'h0 |=> zeroRun) else $error("zero divide");
	div_time_a: assert property (take && opc == `CCD_OPC_DIV &&
		issue.srcA != 32'h0 |=> divRun) else $error("divide time");
	get_nb_a: assert property (take && opc == `CCD_OPC_GET &&
		issue.instr[14] |=> !done ##1 done) else $error("nb get time");
	get_busy_a: assert property (take && opc == `CCD_OPC_GET |=>
		!issueReady) else $error("get not stalled");
	pop_done_a: assert property (|strmRead |-> done && destWe)
		else $error("pop without result");
	imm_hold_a: assert property (take && opc == `CCD_OPC_IMM |=>
		done && immPending) else $error("prefix not held");
	half_align_a: assert property (memReq && memHalf |-> !memAddr[0])
		else $error("half address odd");
	req_hold_a: assert property (memReq && !memAck |=>
		memReq && $stable(memAddr)) else $error("load request dropped");
endmodule // ccd_exec_sva

bind ccd_exec ccd_exec_sva #(.NUM_LINKS(NUM_LINKS)) sva (
	.mclk(mclk), .srst(srst), .issueValid(issueValid), .issue(issue),
	.issueReady(issueReady), .done(done), .destWe(destWe),
	.destValue(destValue), .memReq(memReq), .memAddr(memAddr),
	.memHalf(memHalf), .memAck(memAck), .strmRead(strmRead),
	.status(status), .immPending(immPending)
);

/* test/ccd_link_model.sv */
// far-side model: stream word sources and a load memory
`timescale 1ns/1ns
module ccd_link_model
	import ccd_pkg::*;
#(
	parameter int NUM_LINKS = 8
)(
	input wire logic                 mclk,
	input wire logic                 srst,
	input wire logic                 memReq,
	input wire logic [31:0]          memAddr,
	output logic                     memAck,
	output logic [15:0]              memRdata,
	output ccd_strm_s                strmIn [NUM_LINKS],
	input wire logic [NUM_LINKS-1:0] strmRead,
	input wire logic                 pushEn,
	input wire logic [2:0]           pushLink,
	input wire logic [31:0]          pushData,
	input wire logic                 pushCtl,
	input wire logic [3:0]           memDelay
);
	logic [3:0]  waitReg;
	logic [15:0] word;
	// word depends on both halves so a lost upper address shows
	assign word = memAddr[15:0] ^ memAddr[31:16];
	assign memAck = memReq && waitReg == memDelay;
	// inverse outside the answer so stale data cannot pass
	assign memRdata = memAck ? word : ~word;
	always_ff @(posedge mclk)
	begin
		waitReg <= (srst || !memReq || memAck) ? 4'h0 : waitReg + 4'h1;
		for (int i = 0; i < NUM_LINKS; i++)
		begin
			if (srst)
				strmIn[i] <= '0;
			else if (pushEn && pushLink == i)
				strmIn[i] <= '{pushData, pushCtl, 1'b1};
			else if (strmRead[i])
				strmIn[i] <= '{~strmIn[i].data, ~strmIn[i].ctl, 1'b0};
		end
	end
endmodule // ccd_link_model

/* test/cpu_compare_divide_stream_load_ops_tb.sv */
// self-checking bench for the compare/divide/stream/load unit
`timescale 1ns/1ns
`include "ccd_map.svh"
module cpu_compare_divide_stream_load_ops_tb
	import ccd_pkg::*;
;
	logic        mclk, issueReady, done, destWe, memReq, memHalf, memAck;
	logic        immPending;
	logic        srst = 1, clkEn = 1, issueValid = 0, errClear = 0;
	logic        pushEn = 0, pushCtl = 0;
	logic [31:0] destValue, memAddr, pushData = 32'h0;
	logic [15:0] memRdata;
	logic [3:0]  memDelay = 4'h0;
	logic [7:0]  strmRead;
	ccd_issue_s  issue = '0;
	ccd_strm_s   strmIn [8];
	ccd_status_s status;
	int          mismatches = 0, checked = 0, lat;

	ccd_exec #(.NUM_LINKS(8)) uut (.mclk(mclk), .srst(srst), .clkEn(clkEn),
		.issueValid(issueValid), .issue(issue), .issueReady(issueReady),
		.done(done), .destWe(destWe), .destValue(destValue),
		.memReq(memReq), .memAddr(memAddr), .memHalf(memHalf),
		.memAck(memAck), .memRdata(memRdata), .strmIn(strmIn),
		.strmRead(strmRead), .errClear(errClear), .status(status),
		.immPending(immPending));
	ccd_link_model #(.NUM_LINKS(8)) link (.mclk(mclk), .srst(srst),
		.memReq(memReq), .memAddr(memAddr), .memAck(memAck),
		.memRdata(memRdata), .strmIn(strmIn), .strmRead(strmRead),
		.pushEn(pushEn), .pushLink(3'h3), .pushData(pushData),
		.pushCtl(pushCtl), .memDelay(memDelay));

	initial
	begin
		mclk = 0;
		forever #25 mclk = ~mclk;
	end

	function automatic logic [31:0] ins(logic [5:0] o, logic [15:0] lo);
		return {o, 10'h000, lo};
	endfunction

	task automatic chk(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// lat counts edges up to the done pulse, the taking edge being the first
	task automatic run(input logic [31:0] i, a, b);
		@(posedge mclk);
		issueValid <= 1'b1;
		issue <= '{i, a, b};
		lat = 0;
		repeat (60)
		begin
			@(posedge mclk);
			issueValid <= 1'b0;
			#1 lat++;
			if (done === 1'b1)
				break;
		end
	endtask

	task automatic push(input logic [31:0] d, input logic c);
		@(posedge mclk);
		pushEn <= 1'b1;
		pushData <= d;
		pushCtl <= c;
		@(posedge mclk);
		pushEn <= 1'b0;
	endtask

	task automatic clear;
		@(posedge mclk);
		errClear <= 1'b1;
		@(posedge mclk);
		errClear <= 1'b0;
		#1 chk("clear", 32'(status), 32'h0);
	endtask

	task automatic t_cmp;
		logic [31:0] av [4];
		logic [31:0] bv [4];
		logic [31:0] a, b, d;
		logic        u;
		av = '{32'h5, 32'h1, 32'h3, 32'hffffffff};
		bv = '{32'h5, 32'h3, 32'h1, 32'h1};
		for (int k = 0; k < 8; k++)
		begin
			a = av[k >> 1];
			b = bv[k >> 1];
			u = k[0];
			d = b - a;
			d[31] = u ? a > b : $signed(a) > $signed(b);
			run(ins(`CCD_OPC_CMP, {14'h0, u, 1'b0}), a, b);
			chk("cmp", destValue, a == b ? 32'h0 : d);
			chk("cmp lat", 32'(lat), 32'h1);
		end
		$display("compare test done");
	endtask

	task automatic t_div;
		logic [31:0] av [4];
		logic [31:0] bv [4];
		logic [31:0] a, b, q;
		logic        u;
		av = '{32'h7, 32'h7, 32'h2, 32'h0};
		bv = '{32'h64, 32'hffffff9c, 32'hfffffff9, 32'h5};
		for (int k = 0; k < 8; k++)
		begin
			a = av[k >> 1];
			b = bv[k >> 1];
			u = k[0];
			if (a == 0)
				q = 32'h0;
			else if (u)
				q = b / a;
			else
				q = $signed(b) / $signed(a);
			run(ins(`CCD_OPC_DIV, {14'h0, u, 1'b0}), a, b);
			chk("div", destValue, q);
			chk("div lat", 32'(lat), a == 0 ? 32'h2 : 32'h22);
			chk("div zero", 32'(status.divZero), 32'(a == 0));
			if (a == 0)
				clear;
		end
		$display("divide test done");
	endtask

	task automatic t_strm;
		push(32'h1234abcd, 1'b0);
		run(ins(`CCD_OPC_GET, 16'h0003), 0, 0);
		chk("get", destValue, 32'h1234abcd);
		chk("get lat", 32'(lat), 32'h2);
		chk("get err", 32'(status.streamErr), 32'h0);
		run(ins(`CCD_OPC_GET, 16'h4003), 0, 0);
		chk("nb empty", 32'(status.carry), 32'h1);
		chk("nb lat", 32'(lat), 32'h2);
		push(32'h0badf00d, 1'b0);
		run(ins(`CCD_OPC_GET, 16'h4003), 0, 0);
		chk("nb full", 32'(status.carry), 32'h0);
		chk("nb data", destValue, 32'h0badf00d);
		fork
			run(ins(`CCD_OPC_GET, 16'h0003), 0, 0);
			begin
				repeat (6) @(posedge mclk);
				push(32'h55aa55aa, 1'b0);
			end
		join
		chk("stall", 32'(lat > 5), 32'h1);
		chk("stall data", destValue, 32'h55aa55aa);
		push(32'h77, 1'b1);
		run(ins(`CCD_OPC_GET, 16'h0003), 0, 0);
		chk("data err", 32'(status.streamErr), 32'h1);
		clear;
		push(32'h88, 1'b0);
		run(ins(`CCD_OPC_GET, 16'h2003), 0, 0);
		chk("ctl err", 32'(status.streamErr), 32'h1);
		clear;
		push(32'h99, 1'b1);
		run(ins(`CCD_OPC_GET, 16'h2003), 0, 0);
		chk("ctl ok", 32'(status.streamErr), 32'h0);
		$display("stream test done");
	endtask

	task automatic t_load;
		run(ins(`CCD_OPC_LBU, 16'h0), 32'h100, 32'h23);
		chk("lbu", destValue, 32'h23);
		run(ins(`CCD_OPC_LHU, 16'h0), 32'h1000, 32'h35);
		chk("lhu", destValue, 32'h1034);
		run(ins(`CCD_OPC_LOAD_BYTE_U_IMM, 16'h8001), 32'h10, 0);
		chk("sext", destValue, 32'hee);
		run(ins(`CCD_OPC_IMM, 16'h0002), 0, 0);
		chk("imm lat", 32'(lat), 32'h1);
		chk("imm held", 32'(immPending), 32'h1);
		run(ins(`CCD_OPC_LOAD_HALF_U_IMM, 16'h0007), 32'h10, 0);
		chk("joined", destValue, 32'h14);
		run(ins(`CCD_OPC_IMM, 16'h0002), 0, 0);
		run(ins(`CCD_OPC_CMP, 16'h0), 0, 0);
		run(ins(`CCD_OPC_LOAD_BYTE_U_IMM, 16'h0007), 32'h10, 0);
		chk("dropped", destValue, 32'h17);
		@(posedge mclk);
		memDelay <= 4'h3;
		run(ins(`CCD_OPC_LBU, 16'h0), 32'h100, 32'h23);
		chk("slow lat", 32'(lat), 32'h5);
		chk("slow lbu", destValue, 32'h23);
		$display("load test done");
	endtask

	initial
	begin
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		#1 chk("rst ready", 32'(issueReady), 32'h1);
		chk("rst status", 32'(status), 32'h0);
		t_cmp;
		t_div;
		t_strm;
		t_load;
		final_report;
	end

	// the tests take well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge mclk);
		mismatches++;
		final_report;
	end
endmodule // cpu_compare_divide_stream_load_ops_tb
